//--- hw/lcp_pkg.sv
// constants, types and helpers shared by the led channel pwm block
// assumes a 50 MHz clock and an apb register port with 32-bit data
//
// Summary of operation
// - eight independent channels, each with own settings
// - five-bit current level code per channel
// - host writes level codes into channel registers
// - level code maps logarithmically onto sink current
// - code 31 full scale, code 0 small non-zero
// - six-bit pwm duty code per channel
// - pwm period about 575 us, on time duty-scaled
// - pump mode chosen automatically from sensed headroom
// - pump starts in 1x, stays while regulating
// - 1x dropout on active channel goes 1.33x
// - 1.33x dropout goes 1.5x
// - 1.5x dropout goes 2x, the top step
// - 1x sufficient returns directly to 1x
// - low power 5 ms after outputs off, bus idle
// - bus traffic leaves low power within 1 ms
// - channel writes staged until apply command
package lcp_pkg;
	localparam int CHANNELS = 8;          // channel count
	localparam int LEVEL_W  = 5;          // current level code width
	localparam int DUTY_W   = 6;          // pwm duty code width
	localparam int CUR_W    = 16;         // converter drive word width
	localparam int CLK_NS   = 20;         // clock period in ns
	// pwm period and the length of one of its 64 steps
	localparam int PWM_PERIOD_NS = 575000;
	localparam int PWM_STEPS     = 64;
	localparam int STEP_CYCLES   = PWM_PERIOD_NS / (PWM_STEPS * CLK_NS);
	// low power entry and wake times
	localparam int IDLE_NS      = 5000000;
	localparam int IDLE_CYCLES  = IDLE_NS / CLK_NS;
	localparam int WAKE_NS      = 1000000;
	localparam int WAKE_CYCLES  = WAKE_NS / CLK_NS;
	// headroom filter interval
	localparam int FILTER_NS     = 50000;
	localparam int FILTER_CYCLES = (FILTER_NS + CLK_NS - 1) / CLK_NS;
	// register byte offsets
	localparam logic [7:0] OFS_OUT_CTRL = 8'h00;
	localparam logic [7:0] OFS_APPLY    = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_LEVEL0   = 8'h20;
	localparam logic [7:0] OFS_DUTY0    = 8'h40;
	// status field positions
	localparam int ST_MODE_LSB = 0;
	localparam int ST_LOWPWR   = 2;
	// reset values
	localparam logic [7:0]         OUT_CTRL_RST = 8'h00;
	localparam logic [LEVEL_W-1:0] LEVEL_RST    = 5'h00;
	localparam logic [DUTY_W-1:0]  DUTY_RST     = 6'h00;
	// log map: log2 slope per code step, ten fraction bits
	localparam logic [7:0] LOG_SLOPE = 8'hAA;

	// charge pump multiplier steps
	typedef enum logic [1:0] {
		PUMP_1X,
		PUMP_133,
		PUMP_15,
		PUMP_2X
	} lcp_mode_type;

	// exponential map of a level code onto the converter word
	function automatic logic [CUR_W-1:0] lcp_log_map(
		input logic [LEVEL_W-1:0] code);
		logic [12:0] x;
		logic [16:0] m;
		x = 13'(code * LOG_SLOPE);
		m = {7'h01, x[9:0]};
		return CUR_W'(m << x[12:10]);
	endfunction
endpackage

//--- hw/lcp_chan.sv
// one led channel: active settings, pwm compare, level converter word
// assumes apply is a one-cycle pulse and step is the shared counter
`timescale 1ns/1ps
module lcp_chan
	import lcp_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic               apply,
	input  wire logic               staged_on,
	input  wire logic [LEVEL_W-1:0] staged_level,
	input  wire logic [DUTY_W-1:0]  staged_duty,
	input  wire logic [DUTY_W-1:0]  step,
	output logic                    active,
	output logic                    sink_en,
	output logic [CUR_W-1:0]        sink_current
);
	logic [DUTY_W-1:0] duty_act;  // duty in force

	// take staged settings only on apply
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			active       <= 1'b0;
			duty_act     <= DUTY_RST;
			sink_current <= lcp_log_map(LEVEL_RST);
		end else if (apply) begin
			active       <= staged_on;
			duty_act     <= staged_duty;
			sink_current <= lcp_log_map(staged_level);
		end
	end

	// sink on while active and the counter sits below the duty code
	always_ff @(posedge clock) begin
		if (!rst_n)
			sink_en <= 1'b0;
		else
			sink_en <= active && (step < duty_act);
	end

	chk_duty_gate: assert property (@(posedge clock) disable iff (!rst_n)
		sink_en |-> ($past(step) < $past(duty_act)) && $past(active))
		else $error("sink enabled outside duty window");
endmodule

//--- hw/lcp_top.sv
// led channel controller: apb registers, pwm, pump sequencer, low power
// assumes an apb master on the same clock and analog sense inputs
// that are already synchronous to it
`timescale 1ns/1ps
module lcp_top
	import lcp_pkg::*;
#(
	parameter int IDLE_LIMIT = IDLE_CYCLES  // low power entry delay
)
(
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic [31:0]                       prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic [lcp_pkg::CHANNELS-1:0] sink_dropout,
	input  wire logic                         onex_ok,
	output logic [lcp_pkg::CHANNELS-1:0]      sink_en,
	output logic [lcp_pkg::CHANNELS-1:0][lcp_pkg::CUR_W-1:0] sink_current,
	output logic [1:0]                        pump_mode,
	output logic                              low_power
);
	import lcp_pkg::*;

	logic [CHANNELS-1:0]              out_ctrl;    // staged on/off mask
	logic [CHANNELS-1:0][LEVEL_W-1:0] level_stg;   // staged level codes
	logic [CHANNELS-1:0][DUTY_W-1:0]  duty_stg;    // staged duty codes
	logic [CHANNELS-1:0]              active;      // channels in force
	logic                             apply;       // apply pulse
	logic                             access;      // apb access phase
	logic                             wr;          // write access
	logic                             is_level;    // address in level bank
	logic                             is_duty;     // address in duty bank
	logic [2:0]                       chan_idx;    // bank index
	logic                             mapped;      // address decodes
	logic [8:0]                       step_div;    // pwm step divider
	logic                             step_en;     // one pulse per step
	logic [DUTY_W-1:0]                pwm_step;    // free pwm counter
	lcp_mode_type                     mode;        // pump step
	lcp_mode_type                     next_mode;   // pump step wanted
	logic                             want_up;     // dropout seen
	logic                             want_down;   // 1x would suffice
	logic [11:0]                      filt_cnt;    // headroom filter
	logic [17:0]                      idle_cnt;    // low power timer
	logic [31:0]                      next_prdata; // read data to capture

	// apb decode; slave never stalls
	assign pready   = 1'b1;
	assign access   = psel && penable;
	assign wr       = access && pwrite;
	assign chan_idx = paddr[4:2];
	assign is_level = (paddr[7:5] == OFS_LEVEL0[7:5]) && (paddr[1:0] == 2'b00);
	assign is_duty  = (paddr[7:5] == OFS_DUTY0[7:5]) && (paddr[1:0] == 2'b00);
	assign mapped   = (paddr == OFS_OUT_CTRL) || (paddr == OFS_APPLY)
		|| (paddr == OFS_STATUS) || is_level || is_duty;
	assign pslverr  = access && !mapped;
	// a write to the apply register hands staged settings over
	assign apply    = wr && (paddr == OFS_APPLY);

	// staged output control mask
	always_ff @(posedge clock) begin
		if (!rst_n)
			out_ctrl <= OUT_CTRL_RST;
		else if (wr && paddr == OFS_OUT_CTRL)
			out_ctrl <= pwdata[CHANNELS-1:0];
	end

	// staged level codes, one register per channel
	always_ff @(posedge clock) begin
		if (!rst_n)
			level_stg <= {CHANNELS{LEVEL_RST}};
		else if (wr && is_level)
			level_stg[chan_idx] <= pwdata[LEVEL_W-1:0];
	end

	// staged duty codes, one register per channel
	always_ff @(posedge clock) begin
		if (!rst_n)
			duty_stg <= {CHANNELS{DUTY_RST}};
		else if (wr && is_duty)
			duty_stg[chan_idx] <= pwdata[DUTY_W-1:0];
	end

	// read data mux; unmapped reads return zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (paddr == OFS_OUT_CTRL)
			next_prdata[CHANNELS-1:0] = out_ctrl;
		else if (paddr == OFS_STATUS) begin
			next_prdata[ST_MODE_LSB +: 2] = mode;
			next_prdata[ST_LOWPWR]        = low_power;
		end else if (is_level)
			next_prdata[LEVEL_W-1:0] = level_stg[chan_idx];
		else if (is_duty)
			next_prdata[DUTY_W-1:0] = duty_stg[chan_idx];
	end

	// read data captured in the setup cycle, steady through the access
	// cycle; status bits show the state at the setup edge
	always_ff @(posedge clock) begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= next_prdata;
	end

	// step divider: one enable pulse per pwm step
	always_ff @(posedge clock) begin
		if (!rst_n)
			step_div <= 9'h000;
		else if (step_en)
			step_div <= 9'h000;
		else
			step_div <= step_div + 9'h001;
	end
	assign step_en = (step_div == 9'(STEP_CYCLES - 1));

	// free running 64-step pwm counter
	always_ff @(posedge clock) begin
		if (!rst_n)
			pwm_step <= 6'h00;
		else if (step_en)
			pwm_step <= pwm_step + 6'h01;
	end

	// eight identical channels
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			lcp_chan u_chan (
				.clock        (clock),
				.rst_n        (rst_n),
				.apply        (apply),
				.staged_on    (out_ctrl[g]),
				.staged_level (level_stg[g]),
				.staged_duty  (duty_stg[g]),
				.step         (pwm_step),
				.active       (active[g]),
				.sink_en      (sink_en[g]),
				.sink_current (sink_current[g])
			);
		end
	endgenerate

	// pump raise request from dropout on active channels only; lower request from onex_ok
	assign want_up   = |(sink_dropout & active) && (mode != PUMP_2X);
	assign want_down = onex_ok && (mode != PUMP_1X) && !want_up;

	// next pump step when the filter expires
	always_comb begin
		next_mode = mode;
		if (want_up) begin
			unique case (mode)
				PUMP_1X:  next_mode = PUMP_133;
				PUMP_133: next_mode = PUMP_15;
				PUMP_15:  next_mode = PUMP_2X;
				PUMP_2X:  next_mode = PUMP_2X;
			endcase
		end else if (want_down)
			next_mode = PUMP_1X;
	end

	// headroom filter: condition must hold for the whole interval
	always_ff @(posedge clock) begin
		if (!rst_n || low_power)
			filt_cnt <= 12'h000;
		else if ((want_up || want_down)
			&& filt_cnt != 12'(FILTER_CYCLES - 1))
			filt_cnt <= filt_cnt + 12'h001;
		else
			filt_cnt <= 12'h000;
	end

	// pump step register; starts and sleeps in 1x
	always_ff @(posedge clock) begin
		if (!rst_n || low_power)
			mode <= PUMP_1X;
		else if (filt_cnt == 12'(FILTER_CYCLES - 1))
			mode <= next_mode;
	end
	assign pump_mode = mode;

	// idle timer: counts while all outputs off and bus quiet
	always_ff @(posedge clock) begin
		if (!rst_n || psel || (|active))
			idle_cnt <= 18'h00000;
		else if (!low_power)
			idle_cnt <= idle_cnt + 18'h00001;
	end

	// low power flag; traffic wakes at once, well within the bound
	always_ff @(posedge clock) begin
		if (!rst_n)
			low_power <= 1'b0;
		else if (psel)
			low_power <= 1'b0;
		else if (idle_cnt == 18'(IDLE_LIMIT - 1) && !(|active))
			low_power <= 1'b1;
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	chk_step_count: assert property (
		step_en |=> (pwm_step == $past(pwm_step) + 6'h01) && step_div == 0)
		else $error("pwm step did not advance on enable");

	chk_sink_masked: assert property (
		(sink_en & ~$past(active)) == '0)
		else $error("inactive channel drives its sink");

	chk_staged_hold: assert property (
		!apply |=> $stable(sink_current) && $stable(active))
		else $error("settings changed without apply");

	chk_up_first: assert property (
		$past(rst_n) && mode == PUMP_133 && $past(mode) != PUMP_133
		|-> $past(mode) == PUMP_1X)
		else $error("1.33x entered from wrong step");

	chk_up_second: assert property (
		$past(rst_n) && mode == PUMP_15 && $past(mode) != PUMP_15
		|-> $past(mode) == PUMP_133)
		else $error("1.5x entered from wrong step");

	chk_up_top: assert property (
		$past(rst_n) && mode == PUMP_2X && $past(mode) != PUMP_2X
		|-> $past(mode) == PUMP_15)
		else $error("2x entered from wrong step");

	chk_down_direct: assert property (
		$past(rst_n) && !$past(low_power) && $fell(mode != PUMP_1X)
		|-> $past(onex_ok))
		else $error("returned to 1x without headroom");

	chk_mode_filter: assert property (
		$past(rst_n) && !$past(low_power) && $changed(mode)
		|-> $past(filt_cnt) == 12'(FILTER_CYCLES - 1))
		else $error("pump step changed before filter expired");

	chk_wake_fast: assert property (
		psel |=> !low_power)
		else $error("low power held during bus traffic");

	chk_sleep_time: assert property (
		$rose(low_power) |-> $past(idle_cnt) == 18'(IDLE_LIMIT - 1)
		&& !$past(|active))
		else $error("low power entered early");

	// settings in force follow the staged mask the cycle after apply
	chk_apply_take: assert property (
		apply |=> active == $past(out_ctrl))
		else $error("apply did not take the staged mask");

	// pump stays in 1x while every active sink regulates
	chk_stay_onex: assert property (
		mode == PUMP_1X && !(|(sink_dropout & active)) |=> mode == PUMP_1X)
		else $error("pump left 1x without dropout");

	// leaving 1x needs a dropout on an active channel
	chk_up_cause: assert property (
		$past(rst_n) && $past(mode) == PUMP_1X && mode != PUMP_1X
		|-> $past(|(sink_dropout & active)))
		else $error("pump raised without sensed dropout");

	// pwm counter moves only on the step enable
	chk_step_hold: assert property (
		!step_en |=> $stable(pwm_step))
		else $error("pwm step moved without enable");

	// divider never runs past one step length
	chk_div_bound: assert property (
		step_div <= 9'(STEP_CYCLES - 1))
		else $error("step divider overran");

	// low power parks the pump in 1x
	chk_sleep_onex: assert property (
		low_power |=> mode == PUMP_1X)
		else $error("pump raised in low power");

	// low power only with every output off
	chk_sleep_dark: assert property (
		low_power |-> !(|active))
		else $error("low power with an active channel");

	// refused accesses read back as zero
	chk_err_read: assert property (
		pslverr |-> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");

	cov_refused: cover property (pslverr);
	cov_pump_top: cover property (mode == PUMP_2X);
	cov_pump_back: cover property (mode == PUMP_15 ##1 mode == PUMP_1X);
	cov_sleep: cover property ($rose(low_power));
	cov_apply_on: cover property (apply ##2 (|sink_en));
endmodule

//--- verif/lcp_sink_model.sv
// behavioural model of the analog sinks and the pump headroom sense
// assumes the bench sets need, the lowest pump step that regulates
`timescale 1ns/1ps
module lcp_sink_model
	import lcp_pkg::*;
(
	input  wire logic [1:0]                   need,
	input  wire logic [1:0]                   pump_mode,
	output logic [lcp_pkg::CHANNELS-1:0]      sink_dropout,
	output logic                              onex_ok
);
	// every sink drops out while the pump sits below the needed step
	assign sink_dropout = (pump_mode < need) ? '1 : '0;
	// plain supply is enough only when no raised step is needed
	assign onex_ok = (need == 2'h0);
endmodule

//--- verif/lcp_top_tb.sv
// bench for lcp_top: apb tasks, staging, pwm, pump and sleep checks
// assumes the sink model on the far side and a 50 MHz clock
`timescale 1ns/1ps
module lcp_top_tb;
	import lcp_pkg::*;
	logic               clock = 1'b0;
	logic               rst_n = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [7:0]         sink_dropout;
	logic               onex_ok;
	logic [7:0]         sink_en;
	logic [7:0][15:0]   sink_current;
	logic [1:0]         pump_mode;
	logic               low_power;
	logic [1:0]         need = 2'h0;   // pump step the sinks need
	logic [31:0]        rd_v;          // last read data
	logic               er_v;          // last error flag
	int                 n_mismatch = 0;
	int                 samples_checked = 0;
	int                 cnt [8];       // sink on cycles per channel
	// per channel level and duty settings
	logic [4:0] lvl [8] = '{5'h00, 5'h1F, 5'h05, 5'h0A,
		5'h10, 5'h14, 5'h19, 5'h01};
	logic [5:0] dty [8] = '{6'h00, 6'h3F, 6'h01, 6'h20,
		6'h10, 6'h30, 6'h07, 6'h3E};

	always #10 clock = ~clock;

	lcp_top #(.IDLE_LIMIT(50)) dut_u (
		.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sink_dropout(sink_dropout),
		.onex_ok(onex_ok), .sink_en(sink_en),
		.sink_current(sink_current), .pump_mode(pump_mode),
		.low_power(low_power));

	lcp_sink_model model_u (.need(need), .pump_mode(pump_mode),
		.sink_dropout(sink_dropout), .onex_ok(onex_ok));

	// expected converter word for a level code
	function automatic logic [15:0] cur_exp(input logic [4:0] c);
		logic [12:0] x;
		logic [16:0] m;
		x = 13'(c) * 13'h0AA;
		m = {7'h01, x[9:0]} << x[12:10];
		return m[15:0];
	endfunction

	// one compare, counted, mismatch reported at once
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, access, wait for pready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd_v = prdata;
		er_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// wait a bounded time for a pump step, then compare
	task wait_mode(input logic [1:0] m, input int lim);
		int n;
		n = 0;
		while (pump_mode !== m && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk(32'(pump_mode), 32'(m));
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked,
			n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end

	// main sequence
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk(32'(pump_mode), 32'h0);
		chk(32'(sink_current[1]), 32'h0400);
		apb(1'b0, 8'h21, 32'h0);
		chk(32'(er_v), 32'h1);
		// stage levels and duties, nothing may move yet
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFS_LEVEL0 + 8'(4 * i), 32'(lvl[i]));
			apb(1'b1, OFS_DUTY0 + 8'(4 * i), 32'(dty[i]));
		end
		apb(1'b1, OFS_OUT_CTRL, 32'h0FF);
		repeat (3) @(posedge clock);
		chk(32'(sink_current[1]), 32'h0400);
		chk(32'(sink_en), 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, OFS_LEVEL0 + 8'(4 * i), 32'h0);
			chk(rd_v, 32'(lvl[i]));
		end
		apb(1'b1, OFS_APPLY, 32'h1);
		repeat (2) @(posedge clock);
		for (int i = 0; i < 8; i++)
			chk(32'(sink_current[i]), 32'(cur_exp(lvl[i])));
		chk(32'(sink_current[1]), 32'h92C0);
		chk(32'(sink_current[0]), 32'h0400);
		// one full pwm period, on cycles per channel
		for (int i = 0; i < 8; i++)
			cnt[i] = 0;
		repeat (PWM_STEPS * STEP_CYCLES) begin
			@(posedge clock);
			for (int i = 0; i < 8; i++)
				cnt[i] += int'(sink_en[i]);
		end
		for (int i = 0; i < 8; i++)
			chk(32'(cnt[i]), 32'(dty[i]) * STEP_CYCLES);
		// pump climbs one step per filter interval
		need <= 2'h3;
		repeat (2400) @(posedge clock);
		chk(32'(pump_mode), 32'h0);
		wait_mode(2'h1, 300);
		wait_mode(2'h2, 2700);
		wait_mode(2'h3, 2700);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rd_v[1:0]), 32'h3);
		need <= 2'h0;
		wait_mode(2'h0, 2700);
		// only two raised steps needed: stop at 1.5x, then back
		need <= 2'h2;
		wait_mode(2'h2, 5400);
		repeat (2700) @(posedge clock);
		chk(32'(pump_mode), 32'h2);
		need <= 2'h0;
		wait_mode(2'h0, 2700);
		// all outputs off, bus quiet: sleep, then wake on access
		apb(1'b1, OFS_OUT_CTRL, 32'h0);
		apb(1'b1, OFS_APPLY, 32'h1);
		repeat (40) @(posedge clock);
		chk(32'(sink_en), 32'h0);
		chk(32'(low_power), 32'h0);
		repeat (20) @(posedge clock);
		chk(32'(low_power), 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(low_power), 32'h0);
		complete_run();
	end
endmodule
